// file: core/wtc_regs.sv
// Purpose: wake sensing, pull select, bus flash mode and cyclic timer register bank
// Assumes: control inputs synchronous, soft reset, restart and fail-safe entry are one-cycle pulses
// Notes: registers reached only over SPI; timer counts 0.1 ms ticks
// Operation
// - measurement select clear after reset
// - measurement active: ignore wake enable, pin config
// - fail output blocks measurement set, flags failure
// - measurement ignores wake enables, level status reset
// - fail-safe entry forces wake pin as source
// - measurement set: no automatic wake pin source
// - pull fields encode none, down, up, auto
// - bus speed bit 4 selects flash mode
// - on-time field decodes stop and run times
// - period field selects cyclic period
// - reserved bits always read zero
// - timer register clears on every reset
// - restart keeps flash bit, clears rest
// - restart keeps pull fields, clears middle
// - new timer config active at chip-select high
// - assigned timer starts on on-time codes 1 to 5
`timescale 1ns/10ps
`default_nettype none
module wtc_regs
   import wtc_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_sclk_i,
   input wire logic spi_mosi_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_o,
   input wire logic soft_reset_i,
   input wire logic restart_i,
   input wire logic failsafe_entry_i,
   input wire logic fail_output_i,
   input wire logic normal_mode_i,
   input wire logic general_pin_is_wake_i,
   input wire logic timer_assigned_i,
   input wire logic wake_pin_level_i,
   input wire logic general_pin_level_i,
   output logic wake_pin_source_enable_o,
   output logic measure_function_o,
   output logic general_pin_config_valid_o,
   output logic wake_pin_level_status_o,
   output logic general_pin_level_status_o,
   output logic [1:0] wake_pin_pull_select_o,
   output logic [1:0] general_pin_pull_select_o,
   output logic flash_mode_o,
   output logic spi_fail_set_o,
   output logic timer_running_o,
   output logic timer_high_side_o
);
   logic [7:0] ext_wake_q;
   logic [7:0] pull_q;
   logic [7:0] bus_q;
   logic [7:0] timer_q;
   logic [6:0] rd_addr;
   logic [7:0] rd_data;
   logic frame_done;
   logic frame_wr;
   logic [6:0] frame_addr;
   logic [7:0] frame_data;
   logic wr_take;
   logic meas_active;
   logic timer_kick_q;
   logic tick;
   logic run;
   logic [15:0] presc_q;
   logic [23:0] tcnt_q;
   logic [23:0] tcnt_inc;
   wtc_tmr_state_type tmr_q;

   wtc_spi_frame u_spi (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .spi_cs_n_i(spi_cs_n_i),
      .spi_sclk_i(spi_sclk_i),
      .spi_mosi_i(spi_mosi_i),
      .rd_data_i(rd_data),
      .rd_addr_o(rd_addr),
      .spi_miso_o(spi_miso_o),
      .spi_miso_oe_o(spi_miso_oe_o),
      .frame_done_o(frame_done),
      .frame_wr_o(frame_wr),
      .frame_addr_o(frame_addr),
      .frame_data_o(frame_data)
   );

   // writes land when chip-select returns high
   assign wr_take = frame_done & frame_wr;
   assign meas_active = ext_wake_q[MEAS_BIT] & ~fail_output_i;

   ////////////////////////////////////////////////////////////////////////////
   // reads; reserved bits are never stored, so they read zero
   always_comb begin
      case (rd_addr)
         EXT_WAKE_ADDR: rd_data = ext_wake_q & EXT_WAKE_WMASK;
         PULL_ADDR: rd_data = pull_q & PULL_WMASK;
         BUS_SPEED_ADDR: rd_data = bus_q & BUS_SPEED_WMASK;
         TIMER_ADDR: rd_data = timer_q & TIMER_WMASK;
         default: rd_data = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ext_wake_q <= EXT_WAKE_RST;
      end else if (soft_reset_i) begin
         ext_wake_q <= EXT_WAKE_RST;
      end else if (restart_i) begin
         ext_wake_q <= ext_wake_q & EXT_WAKE_KEEP;
      end else if (failsafe_entry_i && !ext_wake_q[MEAS_BIT]) begin
         ext_wake_q <= (ext_wake_q & FAILSAFE_KEEP) | FAILSAFE_SET;
      end else if (wr_take && frame_addr == EXT_WAKE_ADDR) begin
         ext_wake_q <= frame_data & EXT_WAKE_WMASK;
         // measurement can never be switched on under an active fail output
         if (fail_output_i) begin
            ext_wake_q[MEAS_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         spi_fail_set_o <= 1'b0;
      end else begin
         spi_fail_set_o <= wr_take && frame_addr == EXT_WAKE_ADDR && frame_data[MEAS_BIT]
            && fail_output_i && !soft_reset_i && !restart_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pull_q <= PULL_RST;
      end else if (soft_reset_i) begin
         pull_q <= PULL_RST;
      end else if (restart_i) begin
         pull_q <= pull_q & PULL_KEEP;
      end else if (wr_take && frame_addr == PULL_ADDR) begin
         pull_q <= frame_data & PULL_WMASK;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_q <= BUS_SPEED_RST;
      end else if (soft_reset_i) begin
         bus_q <= BUS_SPEED_RST;
      end else if (restart_i) begin
         bus_q <= bus_q & BUS_SPEED_KEEP;
      end else if (wr_take && frame_addr == BUS_SPEED_ADDR) begin
         bus_q <= frame_data & BUS_SPEED_WMASK;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer_q <= TIMER_RST;
      end else if (soft_reset_i || restart_i) begin
         timer_q <= TIMER_RST & TIMER_KEEP;
      end else if (wr_take && frame_addr == TIMER_ADDR) begin
         timer_q <= frame_data & TIMER_WMASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin-side view of the configuration
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wake_pin_source_enable_o <= 1'b0;
         measure_function_o <= 1'b0;
         general_pin_config_valid_o <= 1'b0;
         wake_pin_level_status_o <= 1'b0;
         general_pin_level_status_o <= 1'b0;
         wake_pin_pull_select_o <= PULL_NONE;
         general_pin_pull_select_o <= PULL_NONE;
         flash_mode_o <= 1'b0;
      end else begin
         wake_pin_source_enable_o <= ext_wake_q[WAKE_EN_BIT] & ~ext_wake_q[MEAS_BIT];
         measure_function_o <= ext_wake_q[MEAS_BIT] & normal_mode_i;
         general_pin_config_valid_o <= ~meas_active;
         // level status stays in reset while sensing is selected
         wake_pin_level_status_o <= wake_pin_level_i & ~ext_wake_q[MEAS_BIT];
         general_pin_level_status_o <= general_pin_level_i & ~ext_wake_q[MEAS_BIT];
         wake_pin_pull_select_o <= pull_q[WPULL_MSB:0];
         general_pin_pull_select_o <= (general_pin_is_wake_i && !meas_active) ?
            pull_q[GPULL_MSB:GPULL_LSB] : PULL_NONE;
         flash_mode_o <= bus_q[FLASH_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // cyclic timer; a commit restarts the cycle so the new setting is seen at once
   assign run = timer_assigned_i && timer_q[ON_MSB:ON_LSB] != ON_OFF_LOW
      && timer_q[ON_MSB:ON_LSB] <= ON_LAST_RUN;
   assign tick = presc_q == 16'(TICK_CYCLES - 1);
   assign tcnt_inc = tcnt_q + 24'h00_0001;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer_kick_q <= 1'b0;
      end else begin
         timer_kick_q <= wr_take && frame_addr == TIMER_ADDR;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         presc_q <= 16'h0000;
      end else if (tmr_q == TMR_IDLE || timer_kick_q || tick) begin
         presc_q <= 16'h0000;
      end else begin
         presc_q <= presc_q + 16'h0001;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tmr_q <= TMR_IDLE;
         tcnt_q <= 24'h00_0000;
      end else begin
         case (tmr_q)
            TMR_IDLE: begin
               tcnt_q <= 24'h00_0000;
               if (run) begin
                  tmr_q <= TMR_ON;
               end
            end
            TMR_ON, TMR_OFF: begin
               if (!run) begin
                  tmr_q <= TMR_IDLE;
               end else if (timer_kick_q) begin
                  tmr_q <= TMR_ON;
                  tcnt_q <= 24'h00_0000;
               end else if (tick) begin
                  if (tcnt_inc >= wtc_period_ticks(timer_q[PER_MSB:0])) begin
                     tmr_q <= TMR_ON;
                     tcnt_q <= 24'h00_0000;
                  end else begin
                     tcnt_q <= tcnt_inc;
                     if (tcnt_inc >= wtc_on_ticks(timer_q[ON_MSB:ON_LSB])) begin
                        tmr_q <= TMR_OFF;
                     end
                  end
               end
            end
            default: tmr_q <= TMR_IDLE;
         endcase
      end
   end

   // stopped timer drives high only for the off-high code
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer_running_o <= 1'b0;
         timer_high_side_o <= 1'b0;
      end else begin
         timer_running_o <= tmr_q != TMR_IDLE;
         timer_high_side_o <= (tmr_q == TMR_ON)
            || (tmr_q == TMR_IDLE && timer_q[ON_MSB:ON_LSB] == ON_OFF_HIGH);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   meas_reset_clear_a: assert property ($rose(rst_n_i) |-> !ext_wake_q[MEAS_BIT])
      else $error("measurement select set after reset");
   pin_config_ignored_a: assert property (meas_active |=> general_pin_pull_select_o == PULL_NONE
      && !general_pin_config_valid_o) else $error("pin config honoured while measuring");
   meas_fail_block_a: assert property (wr_take && frame_addr == EXT_WAKE_ADDR && frame_data[MEAS_BIT]
      && fail_output_i && !soft_reset_i && !restart_i |=> !ext_wake_q[MEAS_BIT] && spi_fail_set_o)
      else $error("measurement set under fail output");
   level_status_hold_a: assert property (ext_wake_q[MEAS_BIT] |=> !wake_pin_level_status_o
      && !general_pin_level_status_o) else $error("level status updated while measuring");
   failsafe_force_a: assert property (failsafe_entry_i && !ext_wake_q[MEAS_BIT] && !soft_reset_i
      && !restart_i |=> ext_wake_q[WAKE_EN_BIT] ##1 wake_pin_source_enable_o)
      else $error("fail-safe did not enable wake pin");
   meas_no_wake_a: assert property (ext_wake_q[MEAS_BIT] |=> !wake_pin_source_enable_o)
      else $error("wake pin source enabled while measuring");
   reserved_zero_a: assert property ((rd_data & ~(rd_addr == EXT_WAKE_ADDR ? EXT_WAKE_WMASK
      : rd_addr == PULL_ADDR ? PULL_WMASK : rd_addr == BUS_SPEED_ADDR ? BUS_SPEED_WMASK
      : rd_addr == TIMER_ADDR ? TIMER_WMASK : 8'h00)) == 8'h00) else $error("reserved bit reads one");
   timer_restart_clear_a: assert property (restart_i || soft_reset_i |=> timer_q == 8'h00
      ##2 !timer_high_side_o) else $error("timer register survived reset");
   bus_restart_keep_a: assert property (restart_i && !soft_reset_i |=>
      bus_q == ($past(bus_q) & BUS_SPEED_KEEP)) else $error("bus speed restart value wrong");
   pull_restart_keep_a: assert property (restart_i && !soft_reset_i |=>
      pull_q == ($past(pull_q) & PULL_KEEP)) else $error("pull restart value wrong");
   timer_start_a: assert property (timer_kick_q && run |=> tmr_q == TMR_ON ##1 timer_high_side_o)
      else $error("timer did not restart on new config");
endmodule // wtc_regs
`default_nettype wire

// file: inc/wtc_pkg.sv
// Purpose: shared constants for the wake, pull, bus speed and cyclic timer register bank
// Assumes: 100 MHz clock, 16-bit SPI frames with the address byte first
// Notes: restart keep masks mark the bits that survive a restart
`default_nettype none
package wtc_pkg;
   // register addresses (7-bit SPI address field)
   localparam logic [6:0] EXT_WAKE_ADDR = 7'h07;
   localparam logic [6:0] PULL_ADDR = 7'h08;
   localparam logic [6:0] BUS_SPEED_ADDR = 7'h0b;
   localparam logic [6:0] TIMER_ADDR = 7'h0c;
   // reset values after power-on or soft reset
   localparam logic [7:0] EXT_WAKE_RST = 8'h01;
   localparam logic [7:0] PULL_RST = 8'h00;
   localparam logic [7:0] BUS_SPEED_RST = 8'h00;
   localparam logic [7:0] TIMER_RST = 8'h00;
   // bits kept over a restart, all others clear
   localparam logic [7:0] EXT_WAKE_KEEP = 8'hA1;
   localparam logic [7:0] PULL_KEEP = 8'hC3;
   localparam logic [7:0] BUS_SPEED_KEEP = 8'h10;
   localparam logic [7:0] TIMER_KEEP = 8'h00;
   // writable bits; reserved bits read zero
   localparam logic [7:0] EXT_WAKE_WMASK = 8'hA1;
   localparam logic [7:0] PULL_WMASK = 8'hC3;
   localparam logic [7:0] BUS_SPEED_WMASK = 8'h10;
   localparam logic [7:0] TIMER_WMASK = 8'h7F;
   // fail-safe forcing of the external wake control register
   localparam logic [7:0] FAILSAFE_KEEP = 8'hA0;
   localparam logic [7:0] FAILSAFE_SET = 8'h01;
   // field positions
   localparam int MEAS_BIT = 5;
   localparam int WAKE_EN_BIT = 0;
   localparam int FLASH_BIT = 4;
   localparam int ON_LSB = 4;
   localparam int ON_MSB = 6;
   localparam int PER_MSB = 3;
   localparam int GPULL_LSB = 6;
   localparam int GPULL_MSB = 7;
   localparam int WPULL_MSB = 1;
   // pull-select encodings
   localparam logic [1:0] PULL_NONE = 2'h0;
   localparam logic [1:0] PULL_DOWN = 2'h1;
   localparam logic [1:0] PULL_UP = 2'h2;
   localparam logic [1:0] PULL_AUTO = 2'h3;
   // on-time codes that stop the timer, and the last running code
   localparam logic [2:0] ON_OFF_LOW = 3'h0;
   localparam logic [2:0] ON_OFF_HIGH = 3'h6;
   localparam logic [2:0] ON_LAST_RUN = 3'h5;
   // timing: timer counts in ticks of 0.1 ms
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_TIME_NS = 100_000;
   localparam int TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;
   localparam int FRAME_BITS = 16;
   typedef enum logic [1:0] {TMR_IDLE, TMR_ON, TMR_OFF} wtc_tmr_state_type;
   // on-time in ticks for the running codes
   function automatic logic [23:0] wtc_on_ticks(input logic [2:0] code);
      case (code)
         3'h1: wtc_on_ticks = 24'h00_0001;
         3'h2: wtc_on_ticks = 24'h00_0003;
         3'h3: wtc_on_ticks = 24'h00_000A;
         3'h4: wtc_on_ticks = 24'h00_0064;
         3'h5: wtc_on_ticks = 24'h00_00C8;
         default: wtc_on_ticks = 24'h00_0000;
      endcase
   endfunction
   // period in ticks
   function automatic logic [23:0] wtc_period_ticks(input logic [3:0] code);
      case (code)
         4'h0: wtc_period_ticks = 24'h00_0064;
         4'h1: wtc_period_ticks = 24'h00_00C8;
         4'h2: wtc_period_ticks = 24'h00_01F4;
         4'h3: wtc_period_ticks = 24'h00_03E8;
         4'h4: wtc_period_ticks = 24'h00_07D0;
         4'h5: wtc_period_ticks = 24'h00_1388;
         4'h6: wtc_period_ticks = 24'h00_2710;
         4'h7: wtc_period_ticks = 24'h00_4E20;
         4'h8: wtc_period_ticks = 24'h00_C350;
         4'h9: wtc_period_ticks = 24'h01_86A0;
         4'hA: wtc_period_ticks = 24'h03_0D40;
         4'hB: wtc_period_ticks = 24'h07_A120;
         4'hC: wtc_period_ticks = 24'h0F_4240;
         4'hD: wtc_period_ticks = 24'h1E_8480;
         4'hE: wtc_period_ticks = 24'h4C_4B40;
         default: wtc_period_ticks = 24'h98_9680;
      endcase
   endfunction
endpackage
`default_nettype wire

// file: core/wtc_spi_frame.sv
// Purpose: SPI frame shifter, LSB first, bit 0 write flag, bits 7:1 address, bits 15:8 data
// Assumes: SPI pins synchronous to clk_i, sclk idle low, sampled on rising sclk
// Notes: a frame of any length but 16 bits is dropped at chip-select release
`timescale 1ns/10ps
`default_nettype none
module wtc_spi_frame
   import wtc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_sclk_i,
   input wire logic spi_mosi_i,
   input wire logic [7:0] rd_data_i,
   output logic [6:0] rd_addr_o,
   output logic spi_miso_o,
   output logic spi_miso_oe_o,
   output logic frame_done_o,
   output logic frame_wr_o,
   output logic [6:0] frame_addr_o,
   output logic [7:0] frame_data_o
);
   logic sclk_q;
   logic cs_n_q;
   logic [15:0] shift_q;
   logic [4:0] cnt_q;
   logic [7:0] obuf_q;
   logic rise;
   logic fall;
   logic [7:0] first_byte;

   assign rise = spi_sclk_i & ~sclk_q & ~spi_cs_n_i;
   assign fall = ~spi_sclk_i & sclk_q & ~spi_cs_n_i;
   assign first_byte = {spi_mosi_i, shift_q[15:9]};
   assign frame_wr_o = shift_q[0];
   assign frame_addr_o = shift_q[7:1];
   assign frame_data_o = shift_q[15:8];

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
      end else begin
         sclk_q <= spi_sclk_i;
         cs_n_q <= spi_cs_n_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_q <= 16'h0000;
         cnt_q <= 5'h00;
         rd_addr_o <= 7'h00;
      end else if (spi_cs_n_i && !cs_n_q) begin
         cnt_q <= 5'h00;
      end else if (rise) begin
         shift_q <= {spi_mosi_i, shift_q[15:1]};
         // saturate so an over-long frame never aliases back to 16
         if (cnt_q <= 5'(FRAME_BITS)) begin
            cnt_q <= cnt_q + 5'h01;
         end
         if (cnt_q == 5'h07) begin
            rd_addr_o <= first_byte[7:1];
         end
      end
   end

   // commit only on chip-select release of a whole frame
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         frame_done_o <= 1'b0;
      end else begin
         frame_done_o <= spi_cs_n_i && !cs_n_q && (cnt_q == 5'(FRAME_BITS));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // first byte answers zero, second byte returns the addressed register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         spi_miso_o <= 1'b0;
         spi_miso_oe_o <= 1'b0;
         obuf_q <= 8'h00;
      end else begin
         spi_miso_oe_o <= ~spi_cs_n_i;
         if (spi_cs_n_i) begin
            spi_miso_o <= 1'b0;
         end else if (fall && cnt_q == 5'h08) begin
            spi_miso_o <= rd_data_i[0];
            obuf_q <= {1'b0, rd_data_i[7:1]};
         end else if (fall && cnt_q > 5'h08) begin
            spi_miso_o <= obuf_q[0];
            obuf_q <= {1'b0, obuf_q[7:1]};
         end
      end
   end
endmodule // wtc_spi_frame
`default_nettype wire

// file: testbench/wtc_spi_host.sv
// Purpose: host side SPI master model for the register bank
// Assumes: 16-bit frames, LSB first, bit 0 write flag, sclk levels of at least 2 clocks
// Notes: mosi is inverted after each frame so a stale bit never reads as valid
`timescale 1ns/10ps
`default_nettype none
module wtc_spi_host (
   input wire logic clk_i,
   input wire logic miso_i,
   output logic cs_n_o,
   output logic sclk_o,
   output logic mosi_o,
   output logic rd_valid_o,
   output logic [7:0] rd_data_o
);
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      mosi_o = 1'b0;
      rd_valid_o = 1'b0;
      rd_data_o = 8'h00;
   end
   // sclk held low 3 clocks so the answer bit has settled before the rise
   task automatic xfer(input logic wr, input logic [6:0] adr, input logic [7:0] dat);
      logic [15:0] f;
      f = {dat, adr, wr};
      @(negedge clk_i);
      cs_n_o = 1'b0;
      for (int i = 0; i < 16; i++) begin
         // high level lasts 2 clocks as well
         repeat (2) @(negedge clk_i);
         sclk_o = 1'b0;
         mosi_o = f[i];
         repeat (3) @(negedge clk_i);
         sclk_o = 1'b1;
         if (i > 7) rd_data_o[i-8] = miso_i;
      end
      repeat (2) @(negedge clk_i);
      sclk_o = 1'b0;
      repeat (2) @(negedge clk_i);
      cs_n_o = 1'b1;
      mosi_o = ~mosi_o;
      rd_valid_o = ~wr;
      @(negedge clk_i);
      rd_valid_o = 1'b0;
      repeat (4) @(negedge clk_i);
   endtask
endmodule // wtc_spi_host
`default_nettype wire

// file: testbench/tb.sv
// Purpose: self-checking bench for the wake, pull, bus speed and cyclic timer registers
// Assumes: timer tick shortened to 4 clocks
// Notes: expected read values are queued by the driver and compared by a monitor
`timescale 1ns/10ps
`default_nettype none
module tb;
   import wtc_pkg::*;
   localparam int TC = 4;
   logic clk_i, rst_n_i, spi_cs_n_i, spi_sclk_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o;
   logic soft_reset_i, restart_i, failsafe_entry_i, fail_output_i, normal_mode_i;
   logic general_pin_is_wake_i, timer_assigned_i, wake_pin_level_i, general_pin_level_i;
   logic wake_pin_source_enable_o, measure_function_o, general_pin_config_valid_o;
   logic wake_pin_level_status_o, general_pin_level_status_o, flash_mode_o, spi_fail_set_o;
   logic [1:0] wake_pin_pull_select_o, general_pin_pull_select_o;
   logic timer_running_o, timer_high_side_o, rd_valid, fail_seen;
   logic [7:0] rd_data;
   logic cs_prev = 1'b1;
   logic [7:0] exq[$];
   logic [15:0] lfsr = 16'h000B;
   int n_fail = 0, samples_checked = 0, cyc = 0, rise_c = 0, hi_len = 0, last_hi = 0, last_per = 0;
   int on_t[5] = '{1, 3, 10, 100, 200};
   int per_t[5] = '{100, 200, 100, 500, 1000};
   logic [3:0] per_c[5] = '{4'h0, 4'h1, 4'h0, 4'h2, 4'h3};
   wtc_regs #(.TICK_CYCLES(TC)) wtc_regs_i (.*);
   wtc_spi_host wtc_spi_host_i (.clk_i(clk_i), .miso_i(spi_miso_o), .cs_n_o(spi_cs_n_i),
      .sclk_o(spi_sclk_i), .mosi_o(spi_mosi_i), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      if (n_fail == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      exq.push_back(e);
      wtc_spi_host_i.xfer(1'b0, a, 8'h00);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      wtc_spi_host_i.xfer(1'b1, a, d);
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk_i);
      s = 1'b1;
      @(negedge clk_i);
      s = 1'b0;
      repeat (3) @(negedge clk_i);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // monitor: read results, fail flag pulses, high-phase length and period
   always @(posedge clk_i) begin
      cyc++;
      if (spi_fail_set_o === 1'b1) fail_seen = 1'b1;
      if (rd_valid === 1'b1) chk(32'(rd_data), 32'(exq.pop_front()));
      if (rst_n_i === 1'b1) chk(32'(spi_miso_oe_o), 32'(!cs_prev));
      cs_prev = spi_cs_n_i;
      if (timer_high_side_o === 1'b1) begin
         if (hi_len == 0) begin
            last_per = cyc - rise_c;
            rise_c = cyc;
         end
         hi_len++;
      end else if (hi_len != 0) begin
         last_hi = hi_len;
         hi_len = 0;
      end
   end
   initial begin
      #1_000_000;
      n_fail++;
      complete_run();
   end
   initial begin
      {rst_n_i, soft_reset_i, restart_i, failsafe_entry_i, fail_output_i, fail_seen} = 6'h00;
      {normal_mode_i, general_pin_is_wake_i, timer_assigned_i} = 3'h7;
      lfsr = lfsr_next(lfsr);
      {wake_pin_level_i, general_pin_level_i} = lfsr[1:0];
      repeat (8) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
      rd(EXT_WAKE_ADDR, 8'h01);
      rd(PULL_ADDR, 8'h00);
      rd(BUS_SPEED_ADDR, 8'h00);
      rd(TIMER_ADDR, 8'h00);
      rd(7'h10, 8'h00);
      rd(7'h04, 8'h00);
      chk(32'(wake_pin_level_status_o), 32'(wake_pin_level_i));
      for (int k = 0; k < 4; k++) begin
         lfsr = lfsr_next(lfsr);
         wr(PULL_ADDR, {2'(k), lfsr[3:0], 2'(3 - k)});
         chk(32'({general_pin_pull_select_o, wake_pin_pull_select_o}), 32'({2'(k), 2'(3 - k)}));
         rd(PULL_ADDR, {2'(k), 4'h0, 2'(3 - k)});
      end
      general_pin_is_wake_i = 1'b0;
      repeat (3) @(negedge clk_i);
      chk(32'(general_pin_pull_select_o), 32'(0));
      wr(BUS_SPEED_ADDR, 8'hFF);
      chk(32'(flash_mode_o), 32'(1));
      rd(BUS_SPEED_ADDR, 8'h10);
      wr(TIMER_ADDR, 8'hFF);
      rd(TIMER_ADDR, 8'h7F);
      pulse(restart_i);
      rd(PULL_ADDR, 8'hC0);
      rd(BUS_SPEED_ADDR, 8'h10);
      rd(TIMER_ADDR, 8'h00);
      pulse(soft_reset_i);
      rd(PULL_ADDR, 8'h00);
      rd(BUS_SPEED_ADDR, 8'h00);
      // measurement select against the fail output
      {fail_output_i, wake_pin_level_i, general_pin_level_i, general_pin_is_wake_i} = 4'hF;
      wr(EXT_WAKE_ADDR, 8'h21);
      chk(32'(fail_seen), 32'(1));
      fail_seen = 1'b0;
      rd(EXT_WAKE_ADDR, 8'h01);
      fail_output_i = 1'b0;
      wr(EXT_WAKE_ADDR, 8'h21);
      chk(32'(fail_seen), 32'(0));
      chk(32'({wake_pin_source_enable_o, measure_function_o, general_pin_config_valid_o,
         wake_pin_level_status_o, general_pin_level_status_o}), 32'(5'b01000));
      normal_mode_i = 1'b0;
      repeat (3) @(negedge clk_i);
      chk(32'(measure_function_o), 32'(0));
      pulse(failsafe_entry_i);
      rd(EXT_WAKE_ADDR, 8'h21);
      wr(EXT_WAKE_ADDR, 8'h80);
      pulse(failsafe_entry_i);
      rd(EXT_WAKE_ADDR, 8'h81);
      chk(32'(wake_pin_source_enable_o), 32'(1));
      // timer: unassigned, then every running on-time code
      timer_assigned_i = 1'b0;
      wr(TIMER_ADDR, 8'h10);
      chk(32'(timer_running_o), 32'(0));
      timer_assigned_i = 1'b1;
      for (int k = 0; k < 5; k++) begin
         wr(TIMER_ADDR, {1'b0, 3'(k + 1), per_c[k]});
         chk(32'(timer_running_o), 32'(1));
         repeat (per_t[k] * TC * 2 + 50) @(negedge clk_i);
         chk(32'(last_hi), 32'(on_t[k] * TC));
         chk(32'(last_per), 32'(per_t[k] * TC));
      end
      wr(TIMER_ADDR, 8'h60);
      chk(32'({timer_running_o, timer_high_side_o}), 32'(2'b01));
      wr(TIMER_ADDR, 8'h00);
      chk(32'({timer_running_o, timer_high_side_o}), 32'(2'b00));
      chk(32'(exq.size()), 32'(0));
      complete_run();
   end
endmodule // tb
`default_nettype wire
